// File: design/ugf_pkg.sv
// Package: register map, flag positions and timing for the global flag block
package ugf_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h08;
  localparam logic [7:0] OFS_FLAG_FORCE = 8'h0C;
  localparam logic [7:0] OFS_EN_STATE = 8'h10;
  localparam logic [7:0] OFS_EN_CLEAR = 8'h14;
  localparam logic [7:0] OFS_EN_FORCE = 8'h18;
  localparam logic [7:0] OFS_FRAME = 8'h20;
  localparam logic [7:0] OFS_CONTROL = 8'h24;
  localparam int unsigned BIT_IDLE = 0;
  localparam int unsigned BIT_SOF = 2;
  localparam int unsigned BIT_RST_DONE = 3;
  localparam int unsigned BIT_WAKE = 4;
  localparam int unsigned BIT_RSM_END = 5;
  localparam int unsigned BIT_UP_RSM = 6;
  localparam int unsigned EP_LSB = 12;
  localparam int unsigned EP_COUNT = 7;
  localparam int unsigned FRAME_W = 11;
  localparam int unsigned FRAME_LSB = 3;
  localparam int unsigned CTRL_FREEZE_BIT = 0;
  localparam logic [31:0] EVT_MASK = 32'h0000007D;
  localparam logic [31:0] EP_MASK = 32'h0007F000;
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  localparam logic [31:0] EN_RESET = 32'h00000000;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned IDLE_TIME_MS = 3;
  localparam int unsigned IDLE_CYCLES = IDLE_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned IDLE_CNT_W = 19;
endpackage

// File: design/ugf_idle_timer.sv
// Idle J state timer that raises the suspend event
`timescale 1ns/1ps
module ugf_idle_timer
  import ugf_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus state
  input wire logic bus_idle_j,
  // Event out
  output logic idle_event
);
  typedef struct packed {
    logic [IDLE_CNT_W-1:0] count;
    logic fired;
    logic event_out;
  } ugf_idle_state_type;

  ugf_idle_state_type st_reg;
  ugf_idle_state_type st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.event_out = 1'b0;
    if (!bus_idle_j)
    begin
      st_next.count = '0;
      st_next.fired = 1'b0;
    end
    else if (!st_reg.fired)
    begin
      if (st_reg.count == IDLE_CNT_W'(IDLE_LIMIT - 1))
      begin
        st_next.fired = 1'b1;
        st_next.event_out = 1'b1;
      end
      else
      begin
        st_next.count = st_reg.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign idle_event = st_reg.event_out;
endmodule

// File: design/ugf_wake_detect.sv
// Wakeup detector: filters non-idle line activity, runs while frozen
`timescale 1ns/1ps
module ugf_wake_detect
  import ugf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Line activity
  input wire logic line_non_idle,
  input wire logic own_resume_active,
  // Event out
  output logic wake_event
);
  typedef struct packed {
    logic [1:0] filt;
    logic seen;
    logic event_out;
  } ugf_wake_state_type;

  ugf_wake_state_type st_reg;
  ugf_wake_state_type st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.event_out = 1'b0;
    st_next.filt = {st_reg.filt[0], line_non_idle & ~own_resume_active};
    if (st_reg.filt == 2'h3)
    begin
      if (!st_reg.seen)
      begin
        st_next.event_out = 1'b1;
      end
      st_next.seen = 1'b1;
    end
    else if (st_reg.filt == 2'h0)
    begin
      st_next.seen = 1'b0;
    end
  end

  // Not gated by the freeze control, so wakeup is seen while frozen
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign wake_event = st_reg.event_out;
endmodule

// File: design/ugf_global_irq.sv
// Global interrupt flags, enables and register port of the USB device
`timescale 1ns/1ps
module ugf_global_irq
  import ugf_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // USB engine events
  input wire logic upstream_resume_sent,
  input wire logic own_resume_active,
  input wire logic resume_end_seen,
  input wire logic bus_reset_end_seen,
  input wire logic sof_seen,
  input wire logic [FRAME_W-1:0] sof_frame,
  input wire logic bus_idle_j,
  input wire logic line_non_idle,
  input wire logic [EP_COUNT-1:0] endpoint_irq_src,
  // Outputs
  output logic usb_irq,
  output logic controller_clock_freeze
);
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] enables;
    logic [FRAME_W-1:0] frame_counter_value;
    logic freeze;
    logic irq;
    logic [31:0] rdata;
  } ugf_state_type;

  ugf_state_type st_reg;
  ugf_state_type st_next;
  logic idle_event;
  logic wake_event;

  // Decode of a write strobe at one offset
  function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs,
                                  input logic we);
    wr_hit = we && (a == ofs);
  endfunction

  ugf_idle_timer #(
    .IDLE_LIMIT(IDLE_LIMIT)
  ) u_idle (
    .clock(clock),
    .rst(rst),
    .bus_idle_j(bus_idle_j),
    .idle_event(idle_event)
  );

  ugf_wake_detect u_wake (
    .clock(clock),
    .rst(rst),
    .line_non_idle(line_non_idle),
    .own_resume_active(own_resume_active),
    .wake_event(wake_event)
  );

  logic [31:0] hw_set;
  logic [31:0] sw_clr;
  logic [31:0] sw_set;
  logic [31:0] en_clr;
  logic [31:0] en_set;

  always_comb
  begin
    hw_set = '0;
    hw_set[BIT_UP_RSM] = upstream_resume_sent;
    hw_set[BIT_RSM_END] = resume_end_seen;
    hw_set[BIT_WAKE] = wake_event;
    hw_set[BIT_RST_DONE] = bus_reset_end_seen;
    hw_set[BIT_SOF] = sof_seen;
    hw_set[BIT_IDLE] = idle_event;
    sw_clr = wr_hit(reg_addr, OFS_FLAG_CLEAR, reg_write) ? (reg_wdata & EVT_MASK) : '0;
    sw_set = wr_hit(reg_addr, OFS_FLAG_FORCE, reg_write) ? (reg_wdata & EVT_MASK) : '0;
    en_clr = wr_hit(reg_addr, OFS_EN_CLEAR, reg_write) ? reg_wdata : '0;
    en_set = wr_hit(reg_addr, OFS_EN_FORCE, reg_write) ? reg_wdata : '0;
  end

  logic [31:0] set_all;
  logic [31:0] evt_flags;
  logic [31:0] ep_flags;

  always_comb
  begin
    set_all = hw_set | sw_set;
    evt_flags = ((st_reg.flags & ~sw_clr) | set_all) & EVT_MASK;
    // Suspend and wake flags cancel each other when either is newly set
    if (set_all[BIT_IDLE])
    begin
      evt_flags[BIT_WAKE] = 1'b0;
    end
    if (set_all[BIT_WAKE])
    begin
      evt_flags[BIT_IDLE] = 1'b0;
    end
    ep_flags = '0;
    ep_flags[EP_LSB +: EP_COUNT] = endpoint_irq_src;
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.flags = evt_flags | ep_flags;
    st_next.enables = ((st_reg.enables & ~en_clr) | en_set) & (EVT_MASK | EP_MASK);
    if (sof_seen)
    begin
      st_next.frame_counter_value = sof_frame;
    end
    if (wr_hit(reg_addr, OFS_CONTROL, reg_write))
    begin
      st_next.freeze = reg_wdata[CTRL_FREEZE_BIT];
    end
    st_next.irq = |(st_next.flags & st_next.enables);
    st_next.rdata = '0;
    if (reg_read)
    begin
      case (reg_addr)
        OFS_STATUS: st_next.rdata = st_reg.flags;
        OFS_EN_STATE: st_next.rdata = st_reg.enables;
        OFS_FRAME: st_next.rdata = {18'h00000, st_reg.frame_counter_value, 3'h0};
        OFS_CONTROL: st_next.rdata = {31'h00000000, st_reg.freeze};
        // Clear and force registers and unmapped offsets read zero
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg.flags <= FLAG_RESET;
      st_reg.enables <= EN_RESET;
      st_reg.frame_counter_value <= '0;
      st_reg.freeze <= 1'b0;
      st_reg.irq <= 1'b0;
      st_reg.rdata <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign usb_irq = st_reg.irq;
  assign controller_clock_freeze = st_reg.freeze;

  AST_UP_RESUME_SET: assert property (@(posedge clock) disable iff (rst)
    upstream_resume_sent |=> st_reg.flags[BIT_UP_RSM]) else $error("resume flag not set");
  AST_RSMEND_SET: assert property (@(posedge clock) disable iff (rst)
    resume_end_seen |=> st_reg.flags[BIT_RSM_END]) else $error("resume end flag not set");
  AST_RSTDONE_SET: assert property (@(posedge clock) disable iff (rst)
    bus_reset_end_seen |=> st_reg.flags[BIT_RST_DONE]) else $error("reset end flag missing");
  AST_SOF_FRAME: assert property (@(posedge clock) disable iff (rst)
    sof_seen |=> st_reg.flags[BIT_SOF] && st_reg.frame_counter_value == $past(sof_frame))
    else $error("sof flag or frame wrong");
  AST_WAKE_KILLS_IDLE: assert property (@(posedge clock) disable iff (rst)
    wake_event && !idle_event |=> st_reg.flags[BIT_WAKE] && !st_reg.flags[BIT_IDLE])
    else $error("wake did not clear suspend");
  AST_IDLE_KILLS_WAKE: assert property (@(posedge clock) disable iff (rst)
    idle_event && !wake_event |=> st_reg.flags[BIT_IDLE] && !st_reg.flags[BIT_WAKE])
    else $error("suspend did not clear wake");
  AST_CLR_WORKS: assert property (@(posedge clock) disable iff (rst)
    wr_hit(reg_addr, OFS_FLAG_CLEAR, reg_write) && reg_wdata[BIT_SOF] && !sof_seen
    |=> !st_reg.flags[BIT_SOF]) else $error("flag clear failed");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
    wr_hit(reg_addr, OFS_FLAG_CLEAR, reg_write) && reg_wdata[BIT_RST_DONE] && bus_reset_end_seen
    |=> st_reg.flags[BIT_RST_DONE]) else $error("event lost to clear");
  AST_FORCE_WORKS: assert property (@(posedge clock) disable iff (rst)
    wr_hit(reg_addr, OFS_FLAG_FORCE, reg_write) && reg_wdata[BIT_RSM_END]
    |=> st_reg.flags[BIT_RSM_END]) else $error("flag force failed");
  AST_EN_CLEAR: assert property (@(posedge clock) disable iff (rst)
    wr_hit(reg_addr, OFS_EN_CLEAR, reg_write) && reg_wdata[EP_LSB]
    && !wr_hit(reg_addr, OFS_EN_FORCE, reg_write) |=> !st_reg.enables[EP_LSB])
    else $error("enable clear failed");
  AST_EN_RANGE: assert property (@(posedge clock) disable iff (rst)
    (st_reg.enables & ~(EVT_MASK | EP_MASK)) == '0) else $error("bad enable bit");
  AST_IRQ_GATE: assert property (@(posedge clock) disable iff (rst)
    ##1 usb_irq == |(st_reg.flags & st_reg.enables)) else $error("irq mismatch");
  AST_RD_ZERO: assert property (@(posedge clock) disable iff (rst)
    reg_read && (reg_addr == OFS_EN_CLEAR || reg_addr == OFS_FLAG_CLEAR)
    |=> reg_rdata == '0) else $error("write-only reads nonzero");
endmodule

// File: bench/ugf_host_model.sv
// Upstream host model that produces the bus events seen by the flag block
`timescale 1ns/1ps
module ugf_host_model
  import ugf_pkg::*;
(
  // Clock
  input wire logic clock,
  // Bus events
  output logic resume_end_seen,
  output logic bus_reset_end_seen,
  output logic sof_seen,
  output logic [FRAME_W-1:0] sof_frame,
  output logic bus_idle_j,
  output logic line_non_idle
);
  initial
  begin
    {resume_end_seen, bus_reset_end_seen, sof_seen, bus_idle_j, line_non_idle} = 5'h00;
    sof_frame = 11'h000;
  end
  // One event pulse; frame number is stale junk outside the token
  task automatic pulse(input int sel, input logic [FRAME_W-1:0] fn);
    @(posedge clock);
    sof_seen <= (sel == 0);
    resume_end_seen <= (sel == 1);
    bus_reset_end_seen <= (sel == 2);
    sof_frame <= fn;
    @(posedge clock);
    {sof_seen, resume_end_seen, bus_reset_end_seen} <= 3'h0;
    sof_frame <= ~fn;
  endtask
  // Idle J span or line activity burst of n cycles
  task automatic level(input bit act, input int n);
    @(posedge clock);
    bus_idle_j <= !act;
    line_non_idle <= act;
    repeat (n) @(posedge clock);
    bus_idle_j <= 1'b0;
    line_non_idle <= 1'b0;
  endtask
endmodule

// File: bench/ugf_global_irq_tb.sv
// Self-checking bench for the global interrupt flag block
`timescale 1ns/1ps
module ugf_global_irq_tb
  import ugf_pkg::*;
;
  localparam int LIM = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic upstream_resume_sent = 1'b0;
  logic own_resume_active = 1'b0;
  logic [6:0] endpoint_irq_src = 7'h00;
  logic resume_end_seen, bus_reset_end_seen, sof_seen, bus_idle_j, line_non_idle;
  logic [10:0] sof_frame;
  logic usb_irq, controller_clock_freeze;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  ugf_host_model host_u (.clock(clock), .resume_end_seen(resume_end_seen),
    .bus_reset_end_seen(bus_reset_end_seen), .sof_seen(sof_seen), .sof_frame(sof_frame),
    .bus_idle_j(bus_idle_j), .line_non_idle(line_non_idle));
  ugf_global_irq #(.IDLE_LIMIT(LIM)) dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .upstream_resume_sent(upstream_resume_sent), .own_resume_active(own_resume_active),
    .resume_end_seen(resume_end_seen), .bus_reset_end_seen(bus_reset_end_seen),
    .sof_seen(sof_seen), .sof_frame(sof_frame), .bus_idle_j(bus_idle_j),
    .line_non_idle(line_non_idle), .endpoint_irq_src(endpoint_irq_src), .usb_irq(usb_irq),
    .controller_clock_freeze(controller_clock_freeze));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic t_reset();
    logic [7:0] a[6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h3C};
    foreach (a[i]) rd_chk(a[i], 32'h0);
    chk({31'h0, usb_irq}, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_events();
    logic [31:0] bm[4] = '{32'h04, 32'h20, 32'h08, 32'h40};
    wr(8'h18, 32'h7D);
    rd_chk(8'h10, 32'h7D);
    for (int s = 0; s < 4; s++)
    begin
      if (s < 3)
        host_u.pulse(s, 11'h5A5);
      else
      begin
        @(posedge clock);
        upstream_resume_sent <= 1'b1;
        @(posedge clock);
        upstream_resume_sent <= 1'b0;
      end
      wr(8'h08, 32'h7D ^ bm[s]);
      rd_chk(8'h04, bm[s]);
      chk({31'h0, usb_irq}, 32'h1);
      wr(8'h08, bm[s]);
      rd_chk(8'h04, 32'h0);
      chk({31'h0, usb_irq}, 32'h0);
    end
    rd_chk(8'h20, 32'h2D28);
    $display("t_events done");
  endtask
  task automatic t_enable();
    wr(8'h0C, 32'h04);
    wr(8'h10, 32'h0);
    rd_chk(8'h10, 32'h7D);
    chk({31'h0, usb_irq}, 32'h1);
    wr(8'h14, 32'h04);
    rd_chk(8'h10, 32'h79);
    rd_chk(8'h14, 32'h0);
    chk({31'h0, usb_irq}, 32'h0);
    wr(8'h18, 32'h04);
    wr(8'h08, 32'h04);
    $display("t_enable done");
  endtask
  task automatic t_bus();
    host_u.level(0, LIM - 4);
    rd_chk(8'h04, 32'h0);
    host_u.level(0, LIM + 4);
    rd_chk(8'h04, 32'h1);
    wr(8'h24, 32'h1);
    #1;
    chk({31'h0, controller_clock_freeze}, 32'h1);
    host_u.level(1, 6);
    repeat (3) @(posedge clock);
    rd_chk(8'h04, 32'h10);
    wr(8'h24, 32'h0);
    wr(8'h08, 32'h10);
    own_resume_active <= 1'b1;
    host_u.level(1, 6);
    own_resume_active <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(8'h04, 32'h0);
    wr(8'h0C, 32'h10);
    host_u.level(0, LIM + 4);
    rd_chk(8'h04, 32'h1);
    wr(8'h08, 32'h1);
    $display("t_bus done");
  endtask
  task automatic t_endpoint();
    wr(8'h14, 32'h7D);
    endpoint_irq_src <= 7'h40;
    rd_chk(8'h04, 32'h40000);
    chk({31'h0, usb_irq}, 32'h0);
    wr(8'h18, 32'hC0000);
    rd_chk(8'h10, 32'h40000);
    chk({31'h0, usb_irq}, 32'h1);
    endpoint_irq_src <= 7'h00;
    rd_chk(8'h04, 32'h0);
    $display("t_endpoint done");
  endtask
  task automatic t_race();
    fork
      host_u.pulse(0, 11'h001);
      wr(8'h08, 32'h04);
    join
    rd_chk(8'h04, 32'h04);
    $display("t_race done");
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_enable();
    t_bus();
    t_endpoint();
    t_race();
    wrap_up();
  end
endmodule
